/* hw/dss_pkg.sv */
/*
 * Shared constants and types for the duty-cycle stabilizer and sysref
 * capture control block.
 * Assumes a 32-bit AHB-Lite register bus where every register takes one
 * aligned word, so the byte address is four times the register index.
 */
package dss_pkg;

  // ---------------------------------------------------------------
  // register indices and address width
  // ---------------------------------------------------------------
  localparam logic [11:0] DSS_IDX_STAB_ONE = 12'h11c;
  localparam logic [11:0] DSS_IDX_STAB_TWO = 12'h11e;
  localparam logic [11:0] DSS_IDX_SYSREF   = 12'h120;
  localparam logic [11:0] DSS_IDX_IRQ_STAT = 12'h130;
  localparam logic [11:0] DSS_IDX_IRQ_MASK = 12'h131;
  localparam int          DSS_ADDR_W       = 14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DSS_STAB_POWER_BIT   = 0;
  localparam int DSS_STAB_ENGAGE_BIT  = 1;
  localparam int DSS_SYS_MODE_LSB     = 1;
  localparam int DSS_SYS_EDGE_BIT     = 3;
  localparam int DSS_SYS_FALLING_BIT  = 4;
  localparam int DSS_SYS_FLAG_RST_BIT = 6;
  localparam int DSS_IRQ_EVENT_BIT    = 0;
  localparam int DSS_IRQ_SETUP_BIT    = 1;
  localparam int DSS_IRQ_HOLD_BIT     = 2;

  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] DSS_RST_STAB      = 8'h03;
  localparam logic [7:0] DSS_RST_SYSREF    = 8'h00;
  localparam logic [7:0] DSS_RST_IRQ       = 8'h00;
  localparam logic [7:0] DSS_MASK_STAB     = 8'h03;
  localparam logic [7:0] DSS_MASK_SYSREF   = 8'h5e;
  localparam logic [7:0] DSS_MASK_IRQ      = 8'h07;
  localparam logic [1:0] DSS_MODE_DISABLED = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic engage;    // 1 places the stabilizer in the clock path
    logic power_on;  // 1 powers the stabilizer up
  } dss_stab_t;

  typedef struct packed {
    logic capture_en;  // mode select not disabled
    logic on_falling;  // capture on falling sample-clock edge
    logic high_to_low; // valid transition is high to low
  } dss_sys_cfg_t;

  typedef enum logic [1:0] {
    DSS_PH_IDLE  = 2'b01,
    DSS_PH_WRITE = 2'b10
  } dss_phase_t;

endpackage : dss_pkg

/* hw/dss_sysref_det.sv */
/*
 * Sysref capture and transition detector.
 * Assumes sysref arrives asynchronously on a pin; it is sampled on both
 * clock edges and each path passes two flip-flops before any logic.
 */
`timescale 1ns/1ps
module dss_sysref_det
  import dss_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         sysref_pin,
  input  wire dss_sys_cfg_t cfg,
  output logic              valid_evt
);

  logic rise_s1_r;
  logic rise_s2_r;
  logic fall_s1_r;
  logic fall_s2_r;
  logic level_prev_r;
  logic level_now;

  // ---------------------------------------------------------------
  // synchronisers for rising and falling clock edge sampling
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_s1_r <= 1'b0;
      rise_s2_r <= 1'b0;
    end else begin
      rise_s1_r <= sysref_pin;
      rise_s2_r <= rise_s1_r;
    end
  end

  // falling-edge first stage, second stage back on rising edge
  always_ff @(negedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_s1_r <= 1'b0;
    end else begin
      fall_s1_r <= sysref_pin;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_s2_r <= 1'b0;
    end else begin
      fall_s2_r <= fall_s1_r;
    end
  end

  // pick the sampling edge
  assign level_now = cfg.on_falling ? fall_s2_r : rise_s2_r;

  // ---------------------------------------------------------------
  // transition detection
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_prev_r <= 1'b0;
      valid_evt    <= 1'b0;
    end else begin
      level_prev_r <= level_now;
      if (!cfg.capture_en) begin
        valid_evt <= 1'b0;
      end else if (cfg.high_to_low) begin
        valid_evt <= level_prev_r & ~level_now;
      end else begin
        valid_evt <= ~level_prev_r & level_now;
      end
    end
  end

endmodule : dss_sysref_det

/* hw/dss_ctrl.sv */
/*
 * Duty-cycle stabilizer configuration and sysref capture control,
 * with an AHB-Lite register slave and a level interrupt.
 * Assumes a single AHB-Lite master doing single word transfers, and
 * setup/hold error indications arriving asynchronously on pins.
 */
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module dss_ctrl
  import dss_pkg::*;
#(
  parameter int ADDR_W = DSS_ADDR_W
)
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              sysref_pin,
  input  wire logic              setup_err_pin,
  input  wire logic              hold_err_pin,
  output dss_stab_t              first_duty_stabilizer,
  output dss_stab_t              second_duty_stabilizer,
  output logic                   sysref_valid,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]        stab_one_r;
  logic [7:0]        stab_two_r;
  logic [7:0]        sysref_r;
  logic [7:0]        irq_stat_r;
  logic [7:0]        irq_stat_nxt;
  logic [7:0]        irq_mask_r;
  dss_phase_t        phase_r;
  logic [11:0]       wr_idx_r;
  logic [11:0]       ad_idx;
  logic              addr_ok;
  logic              ad_valid;
  logic              rd_stat;
  logic [7:0]        rd_val;
  logic [7:0]        wr_byte;
  logic              setup_s1_r;
  logic              setup_s2_r;
  logic              hold_s1_r;
  logic              hold_s2_r;
  logic              valid_evt;
  dss_sys_cfg_t      sys_cfg;

  // ---------------------------------------------------------------
  // address phase decode
  // ---------------------------------------------------------------
  assign ad_idx   = 12'(haddr >> 2);
  assign addr_ok  = (haddr[1:0] == 2'h0) && (haddr >> 2) < 14'(4096);
  assign ad_valid = hsel && hready && htrans[1];
  assign wr_byte  = hwdata[7:0];
  assign rd_stat  = ad_valid && !hwrite && addr_ok && (ad_idx == DSS_IDX_IRQ_STAT);

  // read mux; reserved positions come back zero
  always_comb begin
    rd_val = 8'h00;
    if (addr_ok) begin
      unique case (ad_idx)
        DSS_IDX_STAB_ONE: rd_val = stab_one_r & DSS_MASK_STAB;
        DSS_IDX_STAB_TWO: rd_val = stab_two_r & DSS_MASK_STAB;
        DSS_IDX_SYSREF:   rd_val = sysref_r & DSS_MASK_SYSREF;
        DSS_IDX_IRQ_STAT: rd_val = irq_stat_r;
        DSS_IDX_IRQ_MASK: rd_val = irq_mask_r;
        default:          rd_val = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bus phase tracking and read data
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r  <= DSS_PH_IDLE;
      wr_idx_r <= 12'h000;
    end else if (ad_valid && hwrite && addr_ok) begin
      phase_r  <= DSS_PH_WRITE;
      wr_idx_r <= ad_idx;
    end else begin
      phase_r  <= DSS_PH_IDLE;
    end
  end

  // zero wait state, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ad_valid && !hwrite) begin
        hrdata <= {24'h00_0000, rd_val};
      end
    end
  end

  // ---------------------------------------------------------------
  // stabilizer control registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stab_one_r <= DSS_RST_STAB;
      stab_two_r <= DSS_RST_STAB;
    end else if (phase_r == DSS_PH_WRITE) begin
      if (wr_idx_r == DSS_IDX_STAB_ONE) begin
        stab_one_r <= wr_byte & DSS_MASK_STAB;
      end
      if (wr_idx_r == DSS_IDX_STAB_TWO) begin
        stab_two_r <= wr_byte & DSS_MASK_STAB;
      end
    end
  end

  // stabilizer outputs straight from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_duty_stabilizer  <= '{engage: 1'b1, power_on: 1'b1};
      second_duty_stabilizer <= '{engage: 1'b1, power_on: 1'b1};
    end else begin
      first_duty_stabilizer.engage    <= stab_one_r[DSS_STAB_ENGAGE_BIT];
      first_duty_stabilizer.power_on  <= stab_one_r[DSS_STAB_POWER_BIT];
      second_duty_stabilizer.engage   <= stab_two_r[DSS_STAB_ENGAGE_BIT];
      second_duty_stabilizer.power_on <= stab_two_r[DSS_STAB_POWER_BIT];
    end
  end

  // ---------------------------------------------------------------
  // sysref control register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysref_r <= DSS_RST_SYSREF;
    end else if (phase_r == DSS_PH_WRITE && wr_idx_r == DSS_IDX_SYSREF) begin
      sysref_r <= wr_byte & DSS_MASK_SYSREF;
    end
  end

  // capture config; polarity changes are expected only while disabled
  assign sys_cfg.capture_en  = sysref_r[DSS_SYS_MODE_LSB +: 2] != DSS_MODE_DISABLED;
  assign sys_cfg.on_falling  = sysref_r[DSS_SYS_EDGE_BIT];
  assign sys_cfg.high_to_low = sysref_r[DSS_SYS_FALLING_BIT];

  dss_sysref_det u_det (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .sysref_pin (sysref_pin),
    .cfg        (sys_cfg),
    .valid_evt  (valid_evt)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysref_valid <= 1'b0;
    end else begin
      sysref_valid <= valid_evt;
    end
  end

  // ---------------------------------------------------------------
  // error pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup_s1_r <= 1'b0;
      setup_s2_r <= 1'b0;
      hold_s1_r  <= 1'b0;
      hold_s2_r  <= 1'b0;
    end else begin
      setup_s1_r <= setup_err_pin;
      setup_s2_r <= setup_s1_r;
      hold_s1_r  <= hold_err_pin;
      hold_s2_r  <= hold_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, mask and output
  // ---------------------------------------------------------------
  // read clears, a new event in the same cycle wins
  always_comb begin
    irq_stat_nxt = rd_stat ? 8'h00 : irq_stat_r;
    if (valid_evt) begin
      irq_stat_nxt[DSS_IRQ_EVENT_BIT] = 1'b1;
    end
    if (setup_s2_r) begin
      irq_stat_nxt[DSS_IRQ_SETUP_BIT] = 1'b1;
    end
    if (hold_s2_r) begin
      irq_stat_nxt[DSS_IRQ_HOLD_BIT] = 1'b1;
    end
    if (sysref_r[DSS_SYS_FLAG_RST_BIT]) begin
      irq_stat_nxt[DSS_IRQ_SETUP_BIT] = 1'b0;
      irq_stat_nxt[DSS_IRQ_HOLD_BIT]  = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= DSS_RST_IRQ;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= DSS_RST_IRQ;
    end else if (phase_r == DSS_PH_WRITE && wr_idx_r == DSS_IDX_IRQ_MASK) begin
      irq_mask_r <= wr_byte & DSS_MASK_IRQ;
    end
  end

  // registered level interrupt from next-cycle status and mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

endmodule : dss_ctrl

/* verif/dss_ctrl_monitor.sv */
/* Checker for dss_ctrl: stabilizer outputs, sysref events, reserved bits.
   Sees only dss_ctrl ports; bound to every dss_ctrl below. */
`timescale 1ns/1ps
module dss_ctrl_monitor
  import dss_pkg::*;
#(
  parameter int ADDR_W = DSS_ADDR_W
)
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              sysref_pin,
  input wire dss_stab_t         first_duty_stabilizer,
  input wire dss_stab_t         second_duty_stabilizer,
  input wire logic              sysref_valid,
  input wire logic              irq
);
  // ----
  // bus tracking
  // ----
  logic              wr_r;
  logic              rd_r;
  logic [ADDR_W-3:0] wa_r;
  logic [7:0]        cfg_r;

  // data-phase flags and word index
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      wa_r <= '0;
    end else begin
      wr_r <= hsel && hready && htrans[1] && hwrite;
      rd_r <= hsel && hready && htrans[1] && !hwrite;
      wa_r <= haddr[ADDR_W-1:2];
    end
  end

  // shadow of the sysref control word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= DSS_RST_SYSREF;
    end else if (wr_r && wa_r == DSS_IDX_SYSREF) begin
      cfg_r <= hwdata[7:0] & DSS_MASK_SYSREF;
    end
  end

  // ----
  // properties
  // ----
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence wr_one; wr_r && wa_r == DSS_IDX_STAB_ONE; endsequence
  sequence wr_two; wr_r && wa_r == DSS_IDX_STAB_TWO; endsequence
  sequence sys_rise; $rose(sysref_pin) && cfg_r[2:1] != 2'h0 && !cfg_r[4]; endsequence
  sequence sys_fall; $fell(sysref_pin) && cfg_r[2:1] != 2'h0 && cfg_r[4]; endsequence

  // register lands at the data-phase edge, the output flop one edge later
  stab_one_a: assert property (wr_one |=> ##1 first_duty_stabilizer == $past(hwdata[1:0], 2))
    else $error("first stabilizer output differs from write");
  stab_two_a: assert property (wr_two |=> ##1 second_duty_stabilizer == $past(hwdata[1:0], 2))
    else $error("second stabilizer output differs from write");
  reset_out_a: assert property ($rose(hresetn) |-> first_duty_stabilizer == 2'h3 &&
      second_duty_stabilizer == 2'h3 && !sysref_valid && !irq)
    else $error("outputs wrong after reset");
  rise_event_a: assert property (sys_rise |-> ##[2:8] sysref_valid)
    else $error("no event after rising sysref");
  fall_event_a: assert property (sys_fall |-> ##[2:8] sysref_valid)
    else $error("no event after falling sysref");
  valid_pulse_a: assert property (sysref_valid |=> !sysref_valid)
    else $error("event pulse longer than one cycle");
  // read data comes from the status word of the edge before the address phase
  flag_hold_a: assert property (rd_r && wa_r == DSS_IDX_IRQ_STAT && $past(cfg_r[6], 2)
      |-> hrdata[2:1] == 2'h0)
    else $error("error flags seen while held in reset");
  rsvd_sys_a: assert property (rd_r && wa_r == DSS_IDX_SYSREF |-> (hrdata & 32'hffff_ffa1) == 0)
    else $error("reserved sysref bits read nonzero");
  rsvd_stab_a: assert property (rd_r && (wa_r == DSS_IDX_STAB_ONE || wa_r == DSS_IDX_STAB_TWO)
      |-> hrdata[31:2] == 30'h0)
    else $error("reserved stabilizer bits read nonzero");
endmodule : dss_ctrl_monitor

bind dss_ctrl dss_ctrl_monitor #(.ADDR_W(ADDR_W)) i_dss_ctrl_monitor (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .sysref_pin(sysref_pin),
  .first_duty_stabilizer(first_duty_stabilizer), .irq(irq),
  .second_duty_stabilizer(second_duty_stabilizer), .sysref_valid(sysref_valid));

/* verif/dss_clkgen_model.sv */
/* Clock generator side model: sysref and setup/hold error levels.
   Assumes the bench calls set_pins just after a rising clock edge. */
`timescale 1ns/1ps
module dss_clkgen_model (
  input  wire logic hclk,
  output logic      sysref_pin,
  output logic      setup_err_pin,
  output logic      hold_err_pin
);
  // ----
  // pin levels
  // ----
  // quiet pins until told otherwise
  initial begin
    sysref_pin    = 1'b0;
    setup_err_pin = 1'b0;
    hold_err_pin  = 1'b0;
  end

  // new levels after lag extra cycles; prompt or slow
  task automatic set_pins(input logic [2:0] v, input int lag);
    repeat (lag + 1) @(posedge hclk);
    {sysref_pin, setup_err_pin, hold_err_pin} <= v;
  endtask : set_pins
endmodule : dss_clkgen_model

/* verif/duty_stabilizer_sysref_ctrl_test.sv */
/* Self-checking bench for dss_ctrl over AHB-Lite.
   Assumes dss_clkgen_model drives sysref and the error pins. */
`timescale 1ns/1ps
module duty_stabilizer_sysref_ctrl_test import dss_pkg::*;;
  // ----
  // signals and instances
  // ----
  localparam logic [13:0] A_ONE = {DSS_IDX_STAB_ONE, 2'b00};
  localparam logic [13:0] A_TWO = {DSS_IDX_STAB_TWO, 2'b00};
  localparam logic [13:0] A_SYS = {DSS_IDX_SYSREF, 2'b00};
  localparam logic [13:0] A_STA = {DSS_IDX_IRQ_STAT, 2'b00};
  localparam logic [13:0] A_MSK = {DSS_IDX_IRQ_MASK, 2'b00};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, sysref_valid;
  logic        sysref_pin, setup_err_pin, hold_err_pin;
  logic [13:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  dss_stab_t   stab_one, stab_two;
  int          num_errors, checks_done;

  dss_ctrl i_dss_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sysref_pin(sysref_pin),
    .setup_err_pin(setup_err_pin), .hold_err_pin(hold_err_pin), .irq(irq),
    .first_duty_stabilizer(stab_one), .second_duty_stabilizer(stab_two),
    .sysref_valid(sysref_valid));
  dss_clkgen_model i_dss_clkgen_model (.hclk(hclk), .sysref_pin(sysref_pin),
    .setup_err_pin(setup_err_pin), .hold_err_pin(hold_err_pin));

  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one single transfer, then an idle cycle
  task automatic bus(input logic [13:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    @(posedge hclk);
  endtask : bus

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [13:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask : rd

  // watch for an event pulse over a fixed span
  task automatic seek(output logic seen);
    seen = 1'b0;
    repeat (12) begin
      @(posedge hclk);
      if (sysref_valid === 1'b1) seen = 1'b1;
    end
  endtask : seek

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    chk(32'(stab_one), 32'h3);
    chk(32'(stab_two), 32'h3);
    chk(32'(hreadyout), 32'h1);
    chk(32'(hresp), 32'h0);
    rd(A_ONE, 32'h3);
    rd(A_TWO, 32'h3);
    rd(A_SYS, 32'h0);
    rd(14'h4cc, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_stab();
    for (int v = 0; v < 4; v++) begin
      wr(A_ONE, 32'hffff_fffc | 32'(v));
      wr(A_TWO, 32'hffff_fffc | 32'(3 - v));
      rd(A_ONE, 32'(v));
      rd(A_TWO, 32'(3 - v));
      chk(32'(stab_one), 32'(v));
      chk(32'(stab_two), 32'(3 - v));
    end
    $display("test stabilizer done");
  endtask : t_stab

  task automatic t_sysref();
    logic [7:0] cfgs [5] = '{8'h02, 8'h12, 8'h0a, 8'h1a, 8'h00};
    logic       sr, sf, er, ef;
    wr(A_MSK, 32'h1);
    foreach (cfgs[i]) begin
      er = cfgs[i][2:1] != 2'h0 && !cfgs[i][4];
      ef = cfgs[i][2:1] != 2'h0 && cfgs[i][4];
      // polarity and edge set while capture is off, then enabled alone
      wr(A_SYS, {24'h0, cfgs[i] & 8'hf9});
      wr(A_SYS, {24'h0, cfgs[i]});
      i_dss_clkgen_model.set_pins(3'b100, i);
      seek(sr);
      i_dss_clkgen_model.set_pins(3'b000, 0);
      seek(sf);
      wr(A_SYS, {24'h0, cfgs[i] & 8'hf9});
      chk(32'(sr), 32'(er));
      chk(32'(sf), 32'(ef));
      chk(32'(irq), 32'(er | ef));
      rd(A_STA, {31'h0, er | ef});
      chk(32'(irq), 32'h0);
    end
    wr(A_SYS, 32'h0);
    $display("test sysref done");
  endtask : t_sysref

  task automatic t_flags();
    wr(A_MSK, 32'h6);
    i_dss_clkgen_model.set_pins(3'b010, 0);
    repeat (6) @(posedge hclk);
    chk(32'(irq), 32'h1);
    rd(A_STA, 32'h2);
    wr(A_SYS, 32'h40);
    repeat (4) @(posedge hclk);
    rd(A_STA, 32'h0);
    chk(32'(irq), 32'h0);
    // polarity change with capture off, then capture enabled on its own
    wr(A_SYS, 32'hf9);
    rd(A_SYS, 32'h58);
    wr(A_SYS, 32'hff);
    rd(A_SYS, 32'h5e);
    i_dss_clkgen_model.set_pins(3'b001, 0);
    repeat (4) @(posedge hclk);
    rd(A_STA, 32'h0);
    wr(A_SYS, 32'h58);
    wr(A_SYS, 32'h0);
    repeat (4) @(posedge hclk);
    rd(A_STA, 32'h4);
    $display("test flags done");
  endtask : t_flags

  // ----
  // run control
  // ----
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // 4 ns clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // reset, then the scenarios in order
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata} = '0;
    hsel        = 1'b1;
    num_errors  = 0;
    checks_done = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_stab();
    t_sysref();
    t_flags();
    test_done();
  end

  // cut a hang short after 20000 cycles
  initial begin
    #80000;
    num_errors++;
    test_done();
  end
endmodule : duty_stabilizer_sysref_ctrl_test
